// >>> src/fcsr_top.sv
// Purpose: Control, geometry, interrupt and status registers of the flash controller
// Assumes: Single ref_clk domain, AHB-Lite slave with zero wait states
// Notes: Array side events are one-cycle pulses except busy, security and geometry
`timescale 1ns/1ps
`include "fcsr_consts.svh"

// How it works
// R1 - Manual off: writing the last buffer word starts a page write automatically.
// R2 - Manual on: page writes start only through the command field.
// R3 - Manual write bit resets to one.
// R4 - Each flash read waits exactly read_wait_states cycles, zero to fifteen.
// R5 - Read wait states reset to zero, software may raise them.
// R6 - Page size code in bits 18:16, page is eight bytes shifted left.
// R7 - Low half of geometry register reports page count.
// R8 - Enable clear: one disables, zero keeps, read shows enables.
// R9 - Enable set: one enables, zero keeps, same shared enables.
// R10 - Error flag sets on any fault, lock or bad command; write one clears.
// R11 - Ready flag is zero while the array is busy, otherwise one.
// R12 - Status bit eight shows the security bit.
// R13 - Status bit four latches array faults until written one.
// R14 - Status bit three latches locked region programming until written one.
// R15 - Status bit two latches unknown command or wrong key until written one.
// R16 - Status bit one sets on buffer load, clears on write, buffer clear, or one.
// R17 - Power reduced sets on enter command or sleep entry when selected.
// R18 - Power reduced clears on flash access, leave command, or sleep exit; the code clears on sleep exit only in the instant setting.
// R19 - Command 0x42 enters, 0x43 leaves power reduction.
// R20 - Sleep setting picks entry on sleep and exit on access, on wake, or never.
// R21 - Interrupt output is high while an enabled flag is set.
module fcsr_top
  import fcsr_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Flash array side
  input wire fcsr_evt_s evt,
  output fcsr_ctl_s ctl,
  // Interrupt
  output logic irq
);

  // ==========================================
  // Decoding
  function automatic logic at(input logic [7:0] a, input logic [7:0] off);
    at = (a == off);
  endfunction

  function automatic logic cmd_known(input logic [6:0] c);
    cmd_known = (c == `FCSR_CMD_ER) || ((c >= `FCSR_CMD_WP) && (c <= `FCSR_CMD_WAP)) ||
                ((c >= `FCSR_CMD_LR) && (c <= `FCSR_CMD_LAST));
  endfunction

  // ==========================================
  // State
  fcsr_state_s s_q;
  fcsr_state_s s_d;
  logic ahb_go;
  logic cmd_wr;
  logic cmd_ok;
  logic bad_evt;
  logic enter_cmd;
  logic leave_cmd;
  logic pbc_cmd;
  logic page_cmd;
  logic pw_go;
  logic set_pr;
  logic clr_pr;
  logic [31:0] rd_word;

  assign hreadyout = s_q.hreadyout;
  assign hrdata = s_q.hrdata;
  assign hresp = 1'b0;
  assign ctl = s_q.ctl;
  assign irq = s_q.irq;

  // ==========================================
  // Next state
  always_comb begin
    s_d = s_q;
    ahb_go = hsel && hready && htrans[1] && (hsize == 3'h2);
    s_d.wr_pend = ahb_go && hwrite;
    s_d.wr_addr = haddr[7:0];
    s_d.hreadyout = 1'b1;
    s_d.ctl.page_write_start = 1'b0;
    s_d.ctl.cmd_start = 1'b0;
    s_d.ctl.read_done = 1'b0;
    // Command write
    cmd_wr = s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_CMD);
    cmd_ok = cmd_wr && (hwdata[15:8] == `FCSR_CMD_KEY) && cmd_known(hwdata[6:0]);
    bad_evt = cmd_wr && !cmd_ok; // R15
    enter_cmd = cmd_ok && (hwdata[6:0] == `FCSR_CMD_ENTER_POWER_REDUCTION_CMD); // R19
    leave_cmd = cmd_ok && (hwdata[6:0] == `FCSR_CMD_LEAVE_POWER_REDUCTION_CMD); // R19
    pbc_cmd = cmd_ok && (hwdata[6:0] == `FCSR_CMD_PBC);
    page_cmd = cmd_ok && ((hwdata[6:0] == `FCSR_CMD_WP) || (hwdata[6:0] == `FCSR_CMD_WAP)); // R2
    if (cmd_ok) begin
      s_d.ctl.cmd_start = 1'b1;
      s_d.ctl.cmd_code = hwdata[6:0];
    end
    // Page write start, command or auto on last word
    pw_go = page_cmd || (!s_q.ctl.manual_page_write && evt.buf_last_word); // R1
    if (pw_go) begin
      s_d.ctl.page_write_start = 1'b1;
      s_d.ctl.page_write_aux = page_cmd ? (hwdata[6:0] == `FCSR_CMD_WAP) : evt.buf_aux; // R1
    end
    // Control register
    if (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_CTRL)) begin
      s_d.ctl.manual_page_write = hwdata[`FCSR_CTRL_MANUAL_PAGE_WRITE];
      s_d.ctl.read_wait_states = hwdata[`FCSR_CTRL_RWS_HI:`FCSR_CTRL_RWS_LO]; // R5
      s_d.sleep_sel = hwdata[`FCSR_CTRL_SLP_HI:`FCSR_CTRL_SLP_LO];
    end
    // Shared enables behind two views
    if (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_ENCLR)) begin
      s_d.irq_en = s_q.irq_en & ~hwdata[1:0]; // R8
    end
    if (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_ENSET)) begin
      s_d.irq_en = s_q.irq_en | hwdata[1:0]; // R9
    end
    // Write one to clear; set below wins in the same cycle
    if (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_FLAGS) && hwdata[`FCSR_IRQ_ERR]) begin
      s_d.err_flag = 1'b0;
    end
    if (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_STAT)) begin
      if (hwdata[`FCSR_ST_FAULT]) begin
        s_d.array_fault_flag = 1'b0;
      end
      if (hwdata[`FCSR_ST_LOCK]) begin
        s_d.locked_region_violation = 1'b0;
      end
      if (hwdata[`FCSR_ST_BADCMD]) begin
        s_d.bad_command_flag = 1'b0;
      end
      if (hwdata[`FCSR_ST_LOAD]) begin
        s_d.loading = 1'b0;
      end
    end
    if (pw_go || pbc_cmd) begin
      s_d.loading = 1'b0; // R16
    end
    // Event sets
    if (evt.array_fault) begin
      s_d.array_fault_flag = 1'b1; // R13
    end
    if (evt.lock_violation) begin
      s_d.locked_region_violation = 1'b1; // R14
    end
    if (bad_evt) begin
      s_d.bad_command_flag = 1'b1; // R15
    end
    if (evt.buf_load) begin
      s_d.loading = 1'b1; // R16
    end
    if (evt.array_fault || evt.lock_violation || bad_evt) begin
      s_d.err_flag = 1'b1; // R10
    end
    s_d.ready_flag = !evt.array_busy; // R11
    // Power reduction, entry wins over a same-cycle exit
    set_pr = enter_cmd || (evt.sleep_enter && ((s_q.sleep_sel == `FCSR_SLP_ACCESS) ||
             (s_q.sleep_sel == `FCSR_SLP_INSTANT))); // R17 R20
    clr_pr = leave_cmd || evt.flash_access ||
             (evt.sleep_exit && (s_q.sleep_sel == `FCSR_SLP_INSTANT)); // R18 R20
    if (clr_pr) begin
      s_d.ctl.power_reduced_state = 1'b0;
    end
    if (set_pr) begin
      s_d.ctl.power_reduced_state = 1'b1;
    end
    // Read wait sequencer; requests while waiting are ignored
    // Zero waits answer straight from idle, so no read pays a hidden extra cycle
    unique case (s_q.rd_state)
      RD_IDLE: begin
        if (evt.read_req && (s_q.ctl.read_wait_states == 4'h0)) begin
          s_d.ctl.read_done = 1'b1; // R4
        end else if (evt.read_req) begin
          s_d.rd_state = RD_WAIT;
          s_d.rd_cnt = s_q.ctl.read_wait_states - 4'h1; // R4
        end
      end
      RD_WAIT: begin
        if (s_q.rd_cnt == 4'h0) begin
          s_d.ctl.read_done = 1'b1; // R4
          s_d.rd_state = RD_IDLE;
        end else begin
          s_d.rd_cnt = s_q.rd_cnt - 4'h1;
        end
      end
    endcase
    s_d.irq = |({s_d.err_flag, s_d.ready_flag} & s_d.irq_en); // R21
    // Read data from the updated state so a read after a write sees the write
    rd_word = 32'h0;
    if (at(haddr[7:0], `FCSR_OFF_CTRL)) begin
      rd_word[`FCSR_CTRL_MANUAL_PAGE_WRITE] = s_d.ctl.manual_page_write;
      rd_word[`FCSR_CTRL_RWS_HI:`FCSR_CTRL_RWS_LO] = s_d.ctl.read_wait_states;
      rd_word[`FCSR_CTRL_SLP_HI:`FCSR_CTRL_SLP_LO] = s_d.sleep_sel;
    end
    if (at(haddr[7:0], `FCSR_OFF_GEOM)) begin
      rd_word = {13'h0, evt.page_size_code, evt.page_count}; // R6 R7
    end
    if (at(haddr[7:0], `FCSR_OFF_ENCLR) || at(haddr[7:0], `FCSR_OFF_ENSET)) begin
      rd_word[1:0] = s_d.irq_en; // R8 R9
    end
    if (at(haddr[7:0], `FCSR_OFF_FLAGS)) begin
      rd_word[`FCSR_IRQ_ERR] = s_d.err_flag;
      rd_word[`FCSR_IRQ_RDY] = s_d.ready_flag;
    end
    if (at(haddr[7:0], `FCSR_OFF_STAT)) begin
      rd_word[`FCSR_ST_SEC] = evt.security_active; // R12
      rd_word[`FCSR_ST_FAULT] = s_d.array_fault_flag;
      rd_word[`FCSR_ST_LOCK] = s_d.locked_region_violation;
      rd_word[`FCSR_ST_BADCMD] = s_d.bad_command_flag;
      rd_word[`FCSR_ST_LOAD] = s_d.loading;
      rd_word[`FCSR_ST_PRM] = s_d.ctl.power_reduced_state;
    end
    if (ahb_go && !hwrite) begin
      s_d.hrdata = rd_word;
    end
  end

  // ==========================================
  // Registers
  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s_q <= '0;
      s_q.hreadyout <= 1'b1;
      s_q.ctl.manual_page_write <= `FCSR_RST_MANUAL_PAGE_WRITE; // R3
      s_q.ctl.read_wait_states <= `FCSR_RST_RWS; // R5
      s_q.sleep_sel <= `FCSR_RST_SLP;
      s_q.irq_en <= `FCSR_RST_EN;
      s_q.rd_state <= RD_IDLE;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // Checks
  chk_manual_reset: assert property (@(posedge ref_clk) // R3
    $rose(nrst) |-> (s_q.ctl.manual_page_write && s_q.ctl.read_wait_states == 4'h0))
    else $error("manual write or wait states wrong after reset");

  chk_auto_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R1
    (!s_q.ctl.manual_page_write && evt.buf_last_word) |=> ctl.page_write_start)
    else $error("auto page write missing");

  chk_manual_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    (s_q.ctl.manual_page_write && !page_cmd) |=> !ctl.page_write_start)
    else $error("page write without command in manual mode");

  chk_wait_zero: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    (s_q.rd_state == RD_IDLE && evt.read_req && s_q.ctl.read_wait_states == 4'h0)
    |=> ctl.read_done)
    else $error("zero wait read late");

  chk_wait_three: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    (s_q.rd_state == RD_IDLE && evt.read_req && s_q.ctl.read_wait_states == 4'h3)
    |=> !ctl.read_done [*3] ##1 ctl.read_done)
    else $error("three wait read timing wrong");

  chk_en_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // R8
    (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_ENCLR) && hwdata[0]) |=> !s_q.irq_en[0])
    else $error("enable clear failed");

  chk_en_set: assert property (@(posedge ref_clk) disable iff (!nrst) // R9
    (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_ENSET) && hwdata[1]) |=> s_q.irq_en[1])
    else $error("enable set failed");

  chk_err_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    (evt.array_fault || evt.lock_violation || bad_evt) |=> s_q.err_flag)
    else $error("error flag not set");

  chk_ready_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
    evt.array_busy |=> !s_q.ready_flag)
    else $error("ready while busy");

  chk_lock_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
    evt.lock_violation |=> s_q.locked_region_violation)
    else $error("lock violation not latched");

  chk_load_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // R16
    evt.buf_load |=> s_q.loading)
    else $error("load flag not set");

  chk_prm_enter: assert property (@(posedge ref_clk) disable iff (!nrst) // R19
    enter_cmd |=> ctl.power_reduced_state)
    else $error("power reduction not entered");

  chk_irq_out: assert property (@(posedge ref_clk) disable iff (!nrst) // R21
    irq == |({s_q.err_flag, s_q.ready_flag} & s_q.irq_en))
    else $error("irq does not match flags and enables");

  chk_wait_full: assert property (@(posedge ref_clk) disable iff (!nrst) // R4
    (s_q.rd_state == RD_IDLE && evt.read_req && s_q.ctl.read_wait_states == 4'hf)
    |=> !ctl.read_done [*8] ##1 !ctl.read_done [*7] ##1 ctl.read_done)
    else $error("fifteen wait read timing wrong");

  chk_wait_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R5
    (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_CTRL))
    |=> ctl.read_wait_states == $past(hwdata[`FCSR_CTRL_RWS_HI:`FCSR_CTRL_RWS_LO]))
    else $error("wait states not taken from control write");

  chk_manual_write: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_CTRL))
    |=> ctl.manual_page_write == $past(hwdata[`FCSR_CTRL_MANUAL_PAGE_WRITE]))
    else $error("manual write bit not taken from control write");

  chk_page_cmd: assert property (@(posedge ref_clk) disable iff (!nrst) // R2
    page_cmd |=> ctl.page_write_start)
    else $error("page write command did not start a write");

  chk_cmd_start: assert property (@(posedge ref_clk) disable iff (!nrst) // R19
    cmd_ok |=> (ctl.cmd_start && ctl.cmd_code == $past(hwdata[6:0])))
    else $error("accepted command not passed to the array");

  chk_geom_read: assert property (@(posedge ref_clk) disable iff (!nrst) // R6 R7
    (ahb_go && !hwrite && at(haddr[7:0], `FCSR_OFF_GEOM))
    |=> hrdata == {13'h0, $past(evt.page_size_code), $past(evt.page_count)})
    else $error("geometry read wrong");

  chk_sec_read: assert property (@(posedge ref_clk) disable iff (!nrst) // R12
    (ahb_go && !hwrite && at(haddr[7:0], `FCSR_OFF_STAT))
    |=> hrdata[`FCSR_ST_SEC] == $past(evt.security_active))
    else $error("security bit read wrong");

  chk_err_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // R10
    (s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_FLAGS) && hwdata[`FCSR_IRQ_ERR] &&
     !evt.array_fault && !evt.lock_violation && !bad_evt) |=> !s_q.err_flag)
    else $error("error flag not cleared by write one");

  chk_ready_idle: assert property (@(posedge ref_clk) disable iff (!nrst) // R11
    !evt.array_busy |=> s_q.ready_flag)
    else $error("not ready while idle");

  chk_fault_flag: assert property (@(posedge ref_clk) disable iff (!nrst) // R13
    evt.array_fault |=> s_q.array_fault_flag)
    else $error("array fault not latched");

  chk_fault_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R13
    (s_q.array_fault_flag && !(s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_STAT) &&
     hwdata[`FCSR_ST_FAULT])) |=> s_q.array_fault_flag)
    else $error("array fault dropped without write one");

  chk_lock_hold: assert property (@(posedge ref_clk) disable iff (!nrst) // R14
    (s_q.locked_region_violation && !(s_q.wr_pend && at(s_q.wr_addr, `FCSR_OFF_STAT) &&
     hwdata[`FCSR_ST_LOCK])) |=> s_q.locked_region_violation)
    else $error("lock violation dropped without write one");

  chk_bad_key: assert property (@(posedge ref_clk) disable iff (!nrst) // R15
    (cmd_wr && hwdata[15:8] != `FCSR_CMD_KEY) |=> s_q.bad_command_flag)
    else $error("wrong key not flagged");

  chk_load_clear: assert property (@(posedge ref_clk) disable iff (!nrst) // R16
    ((pw_go || pbc_cmd) && !evt.buf_load) |=> !s_q.loading)
    else $error("load flag not cleared by write or buffer clear");

  chk_sleep_enter: assert property (@(posedge ref_clk) disable iff (!nrst) // R17
    (evt.sleep_enter && (s_q.sleep_sel == `FCSR_SLP_ACCESS ||
     s_q.sleep_sel == `FCSR_SLP_INSTANT)) |=> ctl.power_reduced_state)
    else $error("power reduction not entered on sleep");

  chk_prm_leave: assert property (@(posedge ref_clk) disable iff (!nrst) // R18
    (clr_pr && !set_pr) |=> !ctl.power_reduced_state)
    else $error("power reduction not left");

  chk_sleep_off: assert property (@(posedge ref_clk) disable iff (!nrst) // R20
    (evt.sleep_enter && s_q.sleep_sel == `FCSR_SLP_OFF && !set_pr &&
     !ctl.power_reduced_state) |=> !ctl.power_reduced_state)
    else $error("power reduction entered while disabled");

endmodule

// >>> src/fcsr_consts.svh
// Purpose: Offsets, fields, reset values and codes of the flash controller registers
// Assumes: 32-bit AHB-Lite words, byte offsets
// Notes: Definitions only
`ifndef FCSR_CONSTS_SVH
`define FCSR_CONSTS_SVH
// ==========================================
// Register offsets
`define FCSR_OFF_CMD 8'h00
`define FCSR_OFF_CTRL 8'h04
`define FCSR_OFF_GEOM 8'h08
`define FCSR_OFF_ENCLR 8'h0c
`define FCSR_OFF_ENSET 8'h10
`define FCSR_OFF_FLAGS 8'h14
`define FCSR_OFF_STAT 8'h18
// ==========================================
// Field positions
`define FCSR_CTRL_MANUAL_PAGE_WRITE 7
`define FCSR_CTRL_RWS_HI 4
`define FCSR_CTRL_RWS_LO 1
`define FCSR_CTRL_SLP_HI 9
`define FCSR_CTRL_SLP_LO 8
`define FCSR_IRQ_ERR 1
`define FCSR_IRQ_RDY 0
`define FCSR_ST_SEC 8
`define FCSR_ST_FAULT 4
`define FCSR_ST_LOCK 3
`define FCSR_ST_BADCMD 2
`define FCSR_ST_LOAD 1
`define FCSR_ST_PRM 0
// ==========================================
// Reset values
`define FCSR_RST_MANUAL_PAGE_WRITE 1'h1
`define FCSR_RST_RWS 4'h0
`define FCSR_RST_SLP 2'h0
`define FCSR_RST_EN 2'h0
// ==========================================
// Command codes and key
`define FCSR_CMD_WP 7'h04
`define FCSR_CMD_EAR 7'h05
`define FCSR_CMD_WAP 7'h06
`define FCSR_CMD_ER 7'h02
`define FCSR_CMD_LR 7'h40
`define FCSR_CMD_ENTER_POWER_REDUCTION_CMD 7'h42
`define FCSR_CMD_LEAVE_POWER_REDUCTION_CMD 7'h43
`define FCSR_CMD_PBC 7'h44
`define FCSR_CMD_LAST 7'h46
`define FCSR_CMD_KEY 8'ha5
// ==========================================
// Sleep power reduction settings
`define FCSR_SLP_ACCESS 2'h0
`define FCSR_SLP_INSTANT 2'h1
`define FCSR_SLP_OFF 2'h3
`endif

// >>> src/fcsr_pkg.sv
// Purpose: Types of the flash controller register block
// Assumes: Constants come from fcsr_consts.svh
// Notes: State is one packed struct
package fcsr_pkg;
  // ==========================================
  // Read wait sequencer
  typedef enum logic {RD_IDLE, RD_WAIT} fcsr_rd_e;
  // ==========================================
  // Array side events, all synchronous to ref_clk
  typedef struct packed {
    logic array_busy;
    logic array_fault;
    logic lock_violation;
    logic security_active;
    logic buf_load;
    logic buf_last_word;
    logic buf_aux;
    logic sleep_enter;
    logic sleep_exit;
    logic flash_access;
    logic read_req;
    logic [2:0] page_size_code;
    logic [15:0] page_count;
  } fcsr_evt_s;
  // Array side controls
  typedef struct packed {
    logic page_write_start;
    logic page_write_aux;
    logic cmd_start;
    logic [6:0] cmd_code;
    logic power_reduced_state;
    logic manual_page_write;
    logic [3:0] read_wait_states;
    logic read_done;
  } fcsr_ctl_s;
  // Whole block state
  typedef struct packed {
    fcsr_ctl_s ctl;
    logic [1:0] sleep_sel;
    logic [1:0] irq_en;
    logic err_flag;
    logic ready_flag;
    logic array_fault_flag;
    logic locked_region_violation;
    logic bad_command_flag;
    logic loading;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] hrdata;
    logic hreadyout;
    logic irq;
    fcsr_rd_e rd_state;
    logic [3:0] rd_cnt;
  } fcsr_state_s;
endpackage

// >>> sim/fcsr_flash_model.sv
// Purpose: Flash array stand-in on the far side of the register block
// Assumes: All events synchronous to ref_clk
// Notes: Busy time and geometry are plain defaults, not real array figures
`timescale 1ns/1ps
`include "fcsr_consts.svh"
module fcsr_flash_model
  import fcsr_pkg::*;
#(
  parameter int BUSY_N = 20,
  parameter logic [2:0] PAGE_SIZE_CODE = 3'h3,
  parameter logic [15:0] PAGES = 16'h0100
) (
  // Clock
  input wire logic ref_clk,
  // Block side
  input wire fcsr_ctl_s ctl,
  output fcsr_evt_s evt
);
  // ==========================================
  // Pulses and levels
  fcsr_evt_s pul = '0;
  logic sec = 1'b0;
  int busy_cnt = 0;
  always_comb begin
    evt = pul;
    evt.array_busy = (busy_cnt != 0);
    evt.security_active = sec;
    evt.page_size_code = PAGE_SIZE_CODE;
    evt.page_count = PAGES;
  end
  // ==========================================
  // Array goes busy only on work the block launched
  always @(posedge ref_clk) begin
    if (ctl.page_write_start || (ctl.cmd_start && ctl.cmd_code == `FCSR_CMD_ER))
      busy_cnt <= BUSY_N;
    else if (busy_cnt != 0)
      busy_cnt <= busy_cnt - 1;
  end
  // One-cycle event, called just after a rising edge
  task fire(input fcsr_evt_s m);
    pul <= m;
    @(posedge ref_clk);
    pul <= '0;
  endtask
endmodule

// >>> sim/fcsr_top_tb_top.sv
// Purpose: Self-checking bench of the flash controller register block
// Assumes: Zero wait state AHB-Lite slave, single word transfers
// Notes: Expected values built from field positions and model geometry
`timescale 1ns/1ps
`include "fcsr_consts.svh"
module fcsr_top_tb_top
  import fcsr_pkg::*;
;
  // ==========================================
  // Signals
  localparam logic [2:0] PSZ_V = 3'h5;
  localparam logic [15:0] PAGES_V = 16'h0200;
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  logic [31:0] haddr = '0;
  logic [1:0] htrans = '0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = '0;
  logic hreadyout, hresp, irq;
  logic [31:0] hrdata;
  fcsr_evt_s evt;
  fcsr_ctl_s ctl;
  int fail_count = 0;
  int comparisons = 0;
  logic [31:0] wp_cnt = '0;
  logic wp_aux = 1'b0;
  logic [31:0] cmd_seen = '0;
  logic [31:0] rd_cyc = '0;
  logic [31:0] rd_lat = 32'hff;
  logic [31:0] wp;
  logic [31:0] ws [4] = '{32'h0, 32'h3, 32'h7, 32'hf};
  int b;
  always #12.5 ref_clk = ~ref_clk;
  // ==========================================
  // Design and far side
  fcsr_top i_fcsr_top (.ref_clk, .nrst, .hsel(1'b1), .haddr, .htrans, .hwrite,
    .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hrdata, .hresp, .evt, .ctl, .irq);
  fcsr_flash_model #(.PAGE_SIZE_CODE(PSZ_V), .PAGES(PAGES_V)) i_fcsr_flash_model (.ref_clk, .ctl, .evt);
  // ==========================================
  // Observers of array-side strobes
  always @(posedge ref_clk) begin
    if (ctl.page_write_start) begin
      wp_cnt <= wp_cnt + 1;
      wp_aux <= ctl.page_write_aux;
    end
    if (ctl.cmd_start)
      cmd_seen <= {25'h0, ctl.cmd_code};
    rd_cyc <= evt.read_req ? 32'h0 : rd_cyc + 1;
    if (ctl.read_done)
      rd_lat <= rd_cyc;
  end
  // ==========================================
  // Bus and compare tasks
  task complete_run;
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      $display("Error at %0t: got %h expected %h", $time, got, exp);
      fail_count++;
    end
  endtask
  // Bounded wait for hready sampled high
  task wait_rdy;
    int n;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50)
      fail_count++;
  endtask
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge ref_clk);
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    wait_rdy();
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    xfer(1'b1, a, d, x);
  endtask
  task rdchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] x;
    xfer(1'b0, a, 32'h0, x);
    chk(x, exp);
  endtask
  // Fire one array event and let the flag settle
  task pulse(input int k);
    fcsr_evt_s m;
    m = '0;
    case (k)
      0: m.array_fault = 1'b1;
      1: m.lock_violation = 1'b1;
      2: m.buf_load = 1'b1;
      3: begin
        m.buf_last_word = 1'b1;
        m.buf_aux = 1'b1;
      end
      4: m.sleep_enter = 1'b1;
      5: m.sleep_exit = 1'b1;
      6: m.flash_access = 1'b1;
      default: m.read_req = 1'b1;
    endcase
    @(posedge ref_clk);
    i_fcsr_flash_model.fire(m);
    repeat (2) @(posedge ref_clk);
  endtask
  // ==========================================
  // Watchdog, far beyond the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge ref_clk);
    fail_count++;
    complete_run();
  end
  // ==========================================
  // Tests
  initial begin
    repeat (4) @(posedge ref_clk);
    nrst <= 1'b1;
    rdchk(`FCSR_OFF_CTRL, 32'h80);
    chk({31'h0, ctl.manual_page_write}, 32'h1);
    rdchk(`FCSR_OFF_GEOM, {13'h0, PSZ_V, PAGES_V});
    rdchk(`FCSR_OFF_FLAGS, 32'h1);
    rdchk(`FCSR_OFF_STAT, 32'h0);
    wr(8'h20, 32'hffff_ffff);
    rdchk(8'h20, 32'h0);
    wr(`FCSR_OFF_ENSET, 32'h3);
    rdchk(`FCSR_OFF_ENCLR, 32'h3);
    wr(`FCSR_OFF_ENCLR, 32'h1);
    rdchk(`FCSR_OFF_ENSET, 32'h2);
    // Fault, lock, wrong key, unknown code
    for (int k = 0; k < 4; k++) begin
      b = (k == 0) ? `FCSR_ST_FAULT : (k == 1) ? `FCSR_ST_LOCK : `FCSR_ST_BADCMD;
      if (k < 2)
        pulse(k);
      else
        wr(`FCSR_OFF_CMD, (k == 2) ? 32'h0000_0004 : 32'h0000_a507);
      rdchk(`FCSR_OFF_STAT, 32'h1 << b);
      rdchk(`FCSR_OFF_FLAGS, 32'h3);
      chk({31'h0, irq}, 32'h1);
      wr(`FCSR_OFF_STAT, 32'h1 << b);
      wr(`FCSR_OFF_FLAGS, 32'h2);
      rdchk(`FCSR_OFF_FLAGS, 32'h1);
      chk({31'h0, irq}, 32'h0);
    end
    // Automatic then manual page write
    wr(`FCSR_OFF_CTRL, 32'h0);
    pulse(2);
    rdchk(`FCSR_OFF_STAT, 32'h2);
    wp = wp_cnt;
    pulse(3);
    chk(wp_cnt - wp, 32'h1);
    chk({31'h0, wp_aux}, 32'h1);
    rdchk(`FCSR_OFF_FLAGS, 32'h0);
    rdchk(`FCSR_OFF_STAT, 32'h0);
    repeat (30) @(posedge ref_clk);
    rdchk(`FCSR_OFF_FLAGS, 32'h1);
    wr(`FCSR_OFF_CTRL, 32'h80);
    wp = wp_cnt;
    pulse(3);
    chk(wp_cnt - wp, 32'h0);
    wr(`FCSR_OFF_CMD, 32'h0000_a504);
    repeat (2) @(posedge ref_clk);
    chk(wp_cnt - wp, 32'h1);
    chk({31'h0, wp_aux}, 32'h0);
    chk(cmd_seen, 32'h4);
    pulse(2);
    wr(`FCSR_OFF_CMD, 32'h0000_a544);
    rdchk(`FCSR_OFF_STAT, 32'h0);
    repeat (30) @(posedge ref_clk);
    // Read wait states
    foreach (ws[i]) begin
      wr(`FCSR_OFF_CTRL, 32'h80 | (ws[i] << 1));
      rdchk(`FCSR_OFF_CTRL, 32'h80 | (ws[i] << 1));
      chk({28'h0, ctl.read_wait_states}, ws[i]);
      pulse(7);
      repeat (ws[i]) @(posedge ref_clk);
      chk(rd_lat, ws[i]);
    end
    // Power reduction by command and by sleep
    wr(`FCSR_OFF_CMD, 32'h0000_a542);
    rdchk(`FCSR_OFF_STAT, 32'h1);
    chk({31'h0, ctl.power_reduced_state}, 32'h1);
    chk(cmd_seen, 32'h42);
    wr(`FCSR_OFF_CMD, 32'h0000_a543);
    rdchk(`FCSR_OFF_STAT, 32'h0);
    for (int s = 0; s < 4; s++) begin
      wr(`FCSR_OFF_CTRL, 32'h80 | (s << 8));
      pulse(4);
      rdchk(`FCSR_OFF_STAT, (s < 2) ? 32'h1 : 32'h0);
      pulse(5);
      rdchk(`FCSR_OFF_STAT, (s == 0) ? 32'h1 : 32'h0);
      pulse(6);
      rdchk(`FCSR_OFF_STAT, 32'h0);
    end
    i_fcsr_flash_model.sec <= 1'b1;
    rdchk(`FCSR_OFF_STAT, 32'h100);
    complete_run();
  end
endmodule
